// ===== rtl/ua_reset_cfg.svh
// Constants for the unit-attention and reset control block.
// Assumes a 100 MHz mclk; included by the package and the design files.
//
// Functional notes
// R1: Resend Disconnect or Save Data Pointers after a message parity error reply.
// R2: Initiator counts parity retries and clears the device past its threshold.
// R3: Refuse path changes in disconnect; message reject may abandon the sequence.
// R4: Any reset, foreign mode change, eject, autoload or firmware change flags all.
// R5: After unload, first command gets key 6h, later motion commands key 2h.
// R6: Inserted cartridge without autoload or load command reports Not Ready.
// R7: Attention stays pending per initiator until a command other than 12h or 03h.
// R8: Pending attention: inquiry or sense runs and keeps data, others get key 6h.
// R9: After report, inquiry or sense keeps data; other commands run and clear it.
// R10: Several attention events before selection keep only the latest sense data.
// R11: Bus reset held 25 us or device reset message 0Ch both count as resets.
// R12: Device reset leaves the bus, drops queued commands and pending processes.
// R13: Bus or device reset during power-on processing restarts power-on sequence.
// R14: Power-on: bus free, code CRC, servo test, defaults, external and buffer test.
// R15: Bus or device reset: same steps but no buffer memory test; the code also skips the code CRC step.
// R16: Respond within 3 s after power-on, 250 ms after bus or device reset.
// R17: Cartridge present before reset: rewind, reload, end at start of media.
// R18: First command after reset gets key 6h with reset-occurred sense codes.
// R19: During reset with cartridge, non-motion commands run; ready test says becoming ready.
// R20: Option chooses queue one motion command, Busy, or Not Ready during reset or load.
// R21: No cartridge after reset: motion and ready test get key 2h, no tape.
// R22: One pending flag and latest sense record per initiator identifier.
`ifndef UA_RESET_CFG_SVH
`define UA_RESET_CFG_SVH

`define CLK_MHZ 100
`define BUS_RST_MIN_NS 25000
`define BUS_RST_CYC ((`BUS_RST_MIN_NS * `CLK_MHZ + 999) / 1000)
`define POR_LIMIT_MS 3000
`define WARM_LIMIT_MS 250
`define POR_CYC (`POR_LIMIT_MS * `CLK_MHZ * 1000)
`define WARM_CYC (`WARM_LIMIT_MS * `CLK_MHZ * 1000)
`define NUM_INIT 8

`define OP_TUR 8'h00
`define OP_REWIND 8'h01
`define OP_SENSE 8'h03
`define OP_READ 8'h08
`define OP_WRITE 8'h0A
`define OP_WFM 8'h10
`define OP_SPACE 8'h11
`define OP_INQ 8'h12
`define OP_VERIFY 8'h13
`define OP_ERASE 8'h19
`define OP_LOAD 8'h1B
`define OP_LOCATE 8'h2B
`define MSG_DEV_RESET 8'h0C

`define KEY_NONE 4'h0
`define KEY_NOT_READY 4'h2
`define KEY_UA 4'h6

`define ASC_RESET 8'h29
`define ASC_MEDIA_CHG 8'h28
`define ASC_MODE_CHG 8'h2A
`define ASC_FW_CHG 8'h3F
`define ASC_NO_TAPE 8'h3A
`define ASC_BECOMING 8'h04
`define ASCQ_BECOMING 8'h01

// Register map
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_CMD 12'h008
`define REG_ANSWER 12'h00C
`define REG_EVENT 12'h010
`define REG_MSG 12'h014
`define CTRL_RESET 32'h0000_0000

`endif

// ===== rtl/ua_reset_pkg.sv
// Types shared by the unit-attention and reset control block.
// Assumes ua_reset_cfg.svh for all numbers.
`include "ua_reset_cfg.svh"
package ua_reset_pkg;
  typedef enum logic [1:0] {MOTION_QUEUE = 2'b00, MOTION_BUSY = 2'b01,
    MOTION_NOT_READY = 2'b10} motionPolicy_t;
  typedef enum logic [1:0] {ST_GOOD = 2'b00, ST_CHECK = 2'b01, ST_BUSY = 2'b10,
    ST_QUEUED = 2'b11} cmdStatus_t;
  typedef enum logic [2:0] {RS_IDLE = 3'b000, RS_BUSFREE = 3'b001, RS_CRC = 3'b010,
    RS_SERVO = 3'b011, RS_DEFAULTS = 3'b100, RS_EXTMEM = 3'b101, RS_BUFMEM = 3'b110,
    RS_LOAD = 3'b111} resetState_t;
  typedef struct packed {
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } sense_t;
  typedef struct packed {
    logic execute;
    cmdStatus_t status;
    sense_t sense;
  } answer_t;
endpackage

// ===== rtl/ua_sense_store.sv
// Per-initiator unit-attention store: pending flag, reported flag and sense.
// Assumes writes from the control logic on the same clock.
`timescale 1ns/1ns
`include "ua_reset_cfg.svh"
module ua_sense_store
  import ua_reset_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic setAll,
  input sense_t setSense,
  input wire logic [2:0] sel,
  input wire logic wrEn,
  input wire logic wrPending,
  input wire logic wrReported,
  output logic rdPending,
  output logic rdReported,
  output sense_t rdSense
);
  logic [`NUM_INIT-1:0] pendQ;
  logic [`NUM_INIT-1:0] reptQ;
  sense_t senseQ [`NUM_INIT];

  genvar i;
  generate
    for (i = 0; i < `NUM_INIT; i++)
    begin : gEntry
      // New events win over a same-cycle clear; latest event overwrites sense
      always_ff @(posedge mclk)
      begin
        if (reset)
        begin
          pendQ[i] <= 1'b0;
          reptQ[i] <= 1'b0;
          senseQ[i] <= '0;
        end
        else if (setAll)
        begin
          pendQ[i] <= 1'b1; // see R4
          reptQ[i] <= 1'b0;
          senseQ[i] <= setSense; // see R10
        end
        else if (wrEn && sel == 3'(i))
        begin
          pendQ[i] <= wrPending; // see R7
          reptQ[i] <= wrReported;
        end
      end
    end
  endgenerate

  assign rdPending = pendQ[sel]; // see R22
  assign rdReported = reptQ[sel];
  assign rdSense = senseQ[sel];
endmodule // ua_sense_store

// ===== rtl/ua_reset_ctrl.sv
// Target-side command gating, unit attention, reset sequencing, message retry.
// Assumes synchronous event pulses from the drive firmware and an AXI4-Lite master.
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "ua_reset_cfg.svh"
module ua_reset_ctrl
  import ua_reset_pkg::*;
#(
  parameter int PorCycles = `POR_CYC,
  parameter int WarmCycles = `WARM_CYC,
  parameter int StepCycles = 16
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic busResetPin,
  input wire logic cartridgePin,
  input wire logic modeChangeOther,
  input wire logic unloadEject,
  input wire logic autoLoadDone,
  input wire logic firmwareChange,
  input wire logic tapeLoaded,
  input wire logic loadFinished,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic busFree,
  output logic servoReset,
  output logic rewindReload,
  output logic clearQueue,
  output logic resendMsg,
  output logic [2:0] resetStep
);
  // --------------------
  // Pin synchronisers
  // --------------------
  logic [1:0] rstPinQ;
  logic [1:0] cartQ;
  always_ff @(posedge mclk)
  begin
    rstPinQ <= {rstPinQ[0], busResetPin};
    cartQ <= {cartQ[0], cartridgePin};
  end
  wire logic rstLevel = rstPinQ[1];
  wire logic cartPresent = cartQ[1];

  // --------------------
  // Register bus
  // --------------------
  logic [31:0] ctrlQ;
  logic [31:0] cmdQ;
  logic [11:0] awQ;
  logic awHeldQ;
  logic [31:0] wQ;
  logic [3:0] wsQ;
  logic wHeldQ;
  logic bvalidQ;
  logic rvalidQ;
  logic [31:0] rdataQ;
  logic [1:0] rrespQ;
  logic [1:0] brespQ;
  answer_t answerQ;
  logic [7:0] msgQ;
  logic [15:0] retryQ;

  assign awready = !awHeldQ && !bvalidQ;
  assign wready = !wHeldQ && !bvalidQ;
  assign arready = !rvalidQ;
  wire logic awTake = awvalid && awready;
  wire logic wTake = wvalid && wready;
  wire logic [11:0] wAddr = awTake ? awaddr : awQ;
  wire logic [31:0] wData = wTake ? wdata : wQ;
  wire logic [3:0] wStrb = wTake ? wstrb : wsQ;
  wire logic wrFire = (awTake || awHeldQ) && (wTake || wHeldQ);
  wire logic wrCtrl = wrFire && wAddr == `REG_CTRL;
  wire logic wrCmd = wrFire && wAddr == `REG_CMD;
  wire logic wrMsg = wrFire && wAddr == `REG_MSG;
  wire logic wrOk = wrCtrl || wrCmd || wrMsg;
  wire logic [31:0] strbMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};

  // CTRL: [1:0] motion policy, [2] autoload enable, [3] disconnect allowed
  wire motionPolicy_t policy = motionPolicy_t'(ctrlQ[1:0]);
  wire logic autoLoadEn = ctrlQ[2];
  wire logic discAllowed = ctrlQ[3];

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      awHeldQ <= 1'b0;
      wHeldQ <= 1'b0;
      bvalidQ <= 1'b0;
      awQ <= '0;
      wQ <= '0;
      wsQ <= '0;
      brespQ <= 2'h0;
      ctrlQ <= `CTRL_RESET;
    end
    else
    begin
      if (awTake) awQ <= awaddr;
      if (wTake) wQ <= wdata;
      if (wTake) wsQ <= wstrb;
      awHeldQ <= wrFire ? 1'b0 : (awHeldQ || awTake);
      wHeldQ <= wrFire ? 1'b0 : (wHeldQ || wTake);
      if (wrFire)
      begin
        bvalidQ <= 1'b1;
        brespQ <= wrOk ? 2'h0 : 2'h2;
      end
      else if (bready) bvalidQ <= 1'b0;
      if (wrCtrl) ctrlQ <= (ctrlQ & ~strbMask) | (wData & strbMask);
    end
  end
  assign bvalid = bvalidQ;
  assign bresp = brespQ;

  // --------------------
  // Reset detection
  // --------------------
  logic [11:0] rstCntQ;
  logic hardSeenQ;
  always_ff @(posedge mclk)
  begin
    if (reset || !rstLevel)
    begin
      rstCntQ <= '0;
      hardSeenQ <= 1'b0;
    end
    else
    begin
      if (rstCntQ != 12'(`BUS_RST_CYC)) rstCntQ <= rstCntQ + 12'h001;
      if (rstCntQ == 12'(`BUS_RST_CYC - 1)) hardSeenQ <= 1'b1;
    end
  end
  wire logic hardReset = rstLevel && rstCntQ == 12'(`BUS_RST_CYC - 1); // see R11
  wire logic devReset = wrMsg && wData[7:0] == `MSG_DEV_RESET; // see R11
  wire logic warmReset = hardReset || devReset;

  // --------------------
  // Reset sequencer
  // --------------------
  resetState_t stQ;
  logic porQ;
  logic cartAtRstQ;
  logic [31:0] limitQ;
  logic [7:0] stepQ;
  logic porStartQ;
  resetState_t stD;
  always_comb
  begin
    case (stQ)
      RS_BUSFREE: stD = porQ ? RS_CRC : RS_SERVO;
      RS_CRC: stD = RS_SERVO;
      RS_SERVO: stD = RS_DEFAULTS;
      RS_DEFAULTS: stD = RS_EXTMEM;
      RS_EXTMEM: stD = porQ ? RS_BUFMEM : (cartAtRstQ ? RS_LOAD : RS_IDLE); // see R15
      RS_BUFMEM: stD = cartAtRstQ ? RS_LOAD : RS_IDLE; // see R14
      RS_LOAD: stD = RS_IDLE;
      default: stD = RS_IDLE;
    endcase
  end
  wire logic stepDone = stQ == RS_LOAD ? loadFinished : stepQ == 8'(StepCycles - 1);
  wire logic inReset = stQ != RS_IDLE;
  wire logic bootDone = inReset && stD == RS_IDLE && stepDone;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      stQ <= RS_BUSFREE;
      porQ <= 1'b1;
      porStartQ <= 1'b1;
      cartAtRstQ <= 1'b0;
      stepQ <= '0;
      limitQ <= '0;
    end
    else
    begin
      porStartQ <= 1'b0;
      if (warmReset || porStartQ)
      begin
        stQ <= RS_BUSFREE; // see R13
        stepQ <= '0;
        cartAtRstQ <= cartPresent; // see R17
        limitQ <= (porQ && inReset) || porStartQ ? 32'(PorCycles) : 32'(WarmCycles); // see R16
      end
      else
      begin
        if (inReset && stepDone)
        begin
          stQ <= stD;
          stepQ <= '0;
        end
        else if (inReset) stepQ <= stepQ + 8'h01;
        if (limitQ != '0) limitQ <= limitQ - 32'h1;
        if (bootDone) porQ <= 1'b0;
      end
    end
  end
  // Bus answering is held off only until the tape load step
  wire logic busBooting = inReset && stQ != RS_LOAD;
  assign busFree = stQ == RS_BUSFREE || busBooting; // see R14
  assign servoReset = stQ == RS_SERVO; // see R15
  assign rewindReload = stQ == RS_LOAD; // see R17
  assign clearQueue = warmReset; // see R12
  assign resetStep = stQ;

  // --------------------
  // Unit attention store
  // --------------------
  logic unloadSeenQ;
  sense_t evSense;
  wire logic anyEvent = warmReset || porStartQ || modeChangeOther || unloadEject
    || autoLoadDone || firmwareChange;
  always_comb
  begin
    evSense.key = `KEY_UA;
    evSense.ascq = 8'h00;
    if (warmReset || porStartQ) evSense.asc = `ASC_RESET; // see R18
    else if (firmwareChange) evSense.asc = `ASC_FW_CHG;
    else if (modeChangeOther) evSense.asc = `ASC_MODE_CHG;
    else evSense.asc = `ASC_MEDIA_CHG;
  end

  wire logic [2:0] initId = wData[10:8];
  wire logic [7:0] opcode = wData[7:0];
  logic uaPending;
  logic uaReported;
  sense_t uaSense;
  wire logic passive = opcode == `OP_INQ || opcode == `OP_SENSE;
  wire logic motion = opcode == `OP_REWIND || opcode == `OP_READ || opcode == `OP_WRITE
    || opcode == `OP_WFM || opcode == `OP_SPACE || opcode == `OP_VERIFY
    || opcode == `OP_ERASE || opcode == `OP_LOCATE || opcode == `OP_LOAD;
  // Pending+reported with a non-passive command clears; first non-passive reports
  wire logic uaWrite = wrCmd && uaPending && !passive; // see R7
  wire logic uaKeep = uaReported ? 1'b0 : 1'b1; // see R9

  ua_sense_store uStore (
    .mclk(mclk),
    .reset(reset),
    .setAll(anyEvent),
    .setSense(evSense),
    .sel(initId),
    .wrEn(uaWrite),
    .wrPending(uaKeep),
    .wrReported(1'b1),
    .rdPending(uaPending),
    .rdReported(uaReported),
    .rdSense(uaSense)
  );

  // --------------------
  // Command gating
  // --------------------
  logic queuedQ;
  wire logic noTape = !cartPresent || (!porQ && !inReset && !tapeLoaded);
  wire logic notLoaded = cartPresent && !tapeLoaded && !autoLoadEn;
  wire logic loading = stQ == RS_LOAD;
  answer_t ansD;
  always_comb
  begin
    ansD = '{execute: 1'b1, status: ST_GOOD, sense: '0};
    if (uaPending && !uaReported && !passive)
    begin
      ansD = '{execute: 1'b0, status: ST_CHECK, sense: uaSense}; // see R8
    end
    else if (uaPending && passive)
    begin
      ansD.sense = uaSense; // see R8
    end
    else if ((motion || opcode == `OP_TUR) && loading && cartAtRstQ)
    begin
      ansD = '{execute: 1'b0, status: ST_CHECK,
        sense: '{key: `KEY_NOT_READY, asc: `ASC_BECOMING, ascq: `ASCQ_BECOMING}}; // see R19
      if (motion && policy == MOTION_BUSY) ansD.status = ST_BUSY; // see R20
      else if (motion && policy == MOTION_QUEUE && !queuedQ) ansD.status = ST_QUEUED;
    end
    else if ((motion && opcode != `OP_LOAD || opcode == `OP_TUR) && (unloadSeenQ || noTape))
    begin
      ansD = '{execute: 1'b0, status: ST_CHECK,
        sense: '{key: `KEY_NOT_READY, asc: `ASC_NO_TAPE, ascq: 8'h00}}; // see R5 R21
    end
    else if (motion && opcode != `OP_LOAD && notLoaded)
    begin
      ansD = '{execute: 1'b0, status: ST_CHECK,
        sense: '{key: `KEY_NOT_READY, asc: `ASC_BECOMING, ascq: 8'h00}}; // see R6
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      answerQ <= '0;
      cmdQ <= '0;
      queuedQ <= 1'b0;
      unloadSeenQ <= 1'b0;
    end
    else
    begin
      if (wrCmd) cmdQ <= wData;
      if (wrCmd) answerQ <= ansD;
      if (warmReset || bootDone) queuedQ <= 1'b0; // see R12
      else if (wrCmd && ansD.status == ST_QUEUED) queuedQ <= 1'b1; // see R20
      if (unloadEject) unloadSeenQ <= 1'b1; // see R5
      else if (autoLoadDone || (wrCmd && opcode == `OP_LOAD)) unloadSeenQ <= 1'b0;
    end
  end

  // --------------------
  // Disconnect message retry
  // --------------------
  // MSG: [7:0] message out byte, [8] disconnect sequence active
  logic discActQ;
  always_ff @(posedge mclk)
  begin
    if (reset || warmReset)
    begin
      msgQ <= '0;
      discActQ <= 1'b0;
      retryQ <= '0;
    end
    else if (wrMsg)
    begin
      msgQ <= wData[7:0];
      discActQ <= wData[8] && wData[7:0] != 8'h07; // see R3
      if (wData[8] && wData[7:0] == 8'h09) retryQ <= retryQ + 16'h0001; // see R1
    end
  end
  // Path-change requests (extended/identify) are ignored during disconnect
  assign resendMsg = wrMsg && wData[8] && wData[7:0] == 8'h09; // see R1 R3

  // --------------------
  // Read path
  // --------------------
  wire logic [31:0] statusWord = {12'h000, uaPending, uaReported, discActQ, queuedQ,
    unloadSeenQ, cartPresent, hardSeenQ, porQ, limitQ != '0, inReset, 3'(stQ), 5'h00,
    discAllowed, autoLoadEn};
  wire logic [31:0] answerWord = {8'h00, answerQ.execute, 1'b0, answerQ.status,
    answerQ.sense.key, answerQ.sense.asc, answerQ.sense.ascq};
  wire logic [31:0] rdMux = araddr == `REG_CTRL ? ctrlQ : araddr == `REG_STATUS ? statusWord
    : araddr == `REG_CMD ? cmdQ : araddr == `REG_ANSWER ? answerWord
    : araddr == `REG_MSG ? {16'h0000, retryQ} : 32'h0000_0000;
  wire logic rdOk = araddr == `REG_CTRL || araddr == `REG_STATUS || araddr == `REG_CMD
    || araddr == `REG_ANSWER || araddr == `REG_MSG;
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rvalidQ <= 1'b0;
      rdataQ <= '0;
      rrespQ <= 2'h0;
    end
    else if (arvalid && arready)
    begin
      rvalidQ <= 1'b1;
      rdataQ <= rdMux;
      rrespQ <= rdOk ? 2'h0 : 2'h2;
    end
    else if (rready) rvalidQ <= 1'b0;
  end
  assign rvalid = rvalidQ;
  assign rdata = rdataQ;
  assign rresp = rrespQ;
endmodule // ua_reset_ctrl

// ===== verif/ua_initiator_model.sv
// Initiator model on the far side: owns the bus reset line.
// Assumes the device clock; reset lengths are counted in mclk cycles.
`timescale 1ns/1ns
module ua_initiator_model
#(
  parameter int RetryLimit = 2
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic resendMsg,
  input wire logic start,
  input wire logic [11:0] holdLen,
  output logic busResetPin
);
  // ----------------------------------------
  // Bus reset driver
  // ----------------------------------------
  logic [11:0] left_q;
  logic [3:0] retry_q;
  wire giveUp = retry_q > 4'(RetryLimit);
  assign busResetPin = left_q != 12'h000;
  always_ff @(posedge mclk)
  begin
    if (reset)
      left_q <= 12'h000;
    else if (start)
      left_q <= holdLen;
    else if (giveUp)
      left_q <= 12'h9EC;
    else if (busResetPin)
      left_q <= left_q - 12'h001;
    // Counting resends is what qualifies the link; past the limit the target is cleared
    retry_q <= (reset || giveUp) ? 4'h0 : retry_q + 4'(resendMsg);
  end
endmodule // ua_initiator_model

// ===== verif/ua_reset_ctrl_checker.sv
// Concurrent checks on the ports of ua_reset_ctrl.
// Assumes one clock mclk and a synchronous active-high reset.
`timescale 1ns/1ns
module ua_reset_ctrl_checker
#(
  parameter int PorCycles = 100
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic busResetPin,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic busFree,
  input wire logic servoReset,
  input wire logic rewindReload,
  input wire logic clearQueue,
  input wire logic resendMsg,
  input wire logic [2:0] resetStep
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [11:0] hiCnt_q;
  logic hit_q;
  logic warm_q;
  logic [2:0] step_q;
  int busCnt_q;
  wire wrTaken = awvalid && awready && wvalid && wready && awaddr == 12'h014;
  wire warmEnd = resetStep == 3'h0 && step_q != 3'h0;
  always_ff @(posedge mclk)
  begin
    step_q <= resetStep;
    hiCnt_q <= busResetPin ? hiCnt_q + 12'(hiCnt_q != 12'hFFF) : 12'h000;
    hit_q <= busResetPin && (hit_q || clearQueue);
    // Only a reset taken from idle is warm; one inside power-on restarts power-on
    warm_q <= !reset && ((clearQueue && step_q == 3'h0) || (warm_q && !warmEnd));
    busCnt_q <= (busFree && !reset) ? busCnt_q + 1 : 0;
  end
  sequence msgResend;
    wrTaken && wdata[8:0] == 9'h109;
  endsequence
  sequence msgDevReset;
    wrTaken && wdata[7:0] == 8'h0C;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_resend_msg: assert property (msgResend |-> ##[0:2] resendMsg)
    else $error("message resend missing");
  chk_dev_reset: assert property (msgDevReset |-> ##[0:3] clearQueue)
    else $error("device reset message ignored");
  chk_hard_reset: assert property (hiCnt_q == 12'h9E2 |-> hit_q)
    else $error("long bus reset ignored");
  chk_reset_busfree: assert property ($rose(clearQueue) |-> ##[0:3] (resetStep == 3'h1 && busFree))
    else $error("reset did not free the bus");
  chk_servo_state: assert property (servoReset == (resetStep == 3'h3))
    else $error("servo reset outside servo step");
  chk_step_order: assert property ($past(resetStep) == 3'h3 && resetStep != 3'h3 |-> resetStep inside {3'h1, 3'h4})
    else $error("servo step not followed by defaults");
  chk_busfree_steps: assert property (resetStep inside {[3'h1:3'h6]} |-> busFree)
    else $error("bus held during reset steps");
  chk_warm_skips: assert property (warm_q |-> !(resetStep inside {3'h2, 3'h6}))
    else $error("warm reset ran crc or buffer test");
  chk_reload_state: assert property (rewindReload |-> resetStep == 3'h7 && !busFree)
    else $error("reload outside load step");
  chk_bus_timely: assert property (busCnt_q <= PorCycles)
    else $error("bus not answered in time");
endmodule // ua_reset_ctrl_checker

bind ua_reset_ctrl ua_reset_ctrl_checker #(.PorCycles(PorCycles)) ua_reset_ctrl_checker_inst (
  .mclk, .reset, .busResetPin, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready,
  .busFree, .servoReset, .rewindReload, .clearQueue, .resendMsg, .resetStep);

// ===== verif/ua_reset_ctrl_tb.sv
// Self-checking bench for ua_reset_ctrl with an initiator model on the bus side.
// Assumes shortened reset timing and the command/answer register pair.
`timescale 1ns/1ns
`include "ua_reset_cfg.svh"
`define check(name, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      nMismatch++; \
      $display("wrong value %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module scsi_unit_attention_reset_ctrl_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cartridgePin = 1'b0, tapeLoaded = 1'b0, loadFinished = 1'b0;
  logic modeChangeOther = 1'b0, unloadEject = 1'b0, autoLoadDone = 1'b0, firmwareChange = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000, holdLen = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic start = 1'b0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic busResetPin, awready, wready, bvalid, arready, rvalid, busFree, servoReset;
  logic rewindReload, clearQueue, resendMsg;
  logic [2:0] resetStep;
  int nMismatch = 0, checked = 0, nClear = 0, nResend = 0, cycles = 0;
  ua_reset_ctrl #(.PorCycles(100), .WarmCycles(100), .StepCycles(4)) ua_reset_ctrl_inst (
    .mclk, .reset, .busResetPin, .cartridgePin, .modeChangeOther, .unloadEject, .autoLoadDone,
    .firmwareChange, .tapeLoaded, .loadFinished, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .busFree, .servoReset, .rewindReload, .clearQueue, .resendMsg, .resetStep);
  ua_initiator_model ua_initiator_model_inst (.mclk, .reset, .resendMsg, .start, .holdLen,
    .busResetPin);
  initial forever #5 mclk = ~mclk;
  // Pulses are counted mid-cycle so the count never races the edge
  always @(negedge mclk)
  begin
    nClear += int'(clearQueue === 1'b1);
    nResend += int'(resendMsg === 1'b1);
  end
  // ----------------------------------------
  // Bus and command tasks
  // ----------------------------------------
  task automatic axWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 200);
    r = bresp;
    bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic axRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask
  // Answer layout: execute, spare, status, key, asc, ascq; m hides what a case leaves open
  task automatic ask(input logic [2:0] id, input logic [7:0] op, input logic [23:0] e,
    input logic [23:0] m);
    logic [1:0] r;
    logic [31:0] d;
    axWrite(`REG_CMD, {21'h0, id, op}, r);
    axRead(`REG_ANSWER, d, r);
    `check("answer", e & m, d[23:0] & m)
  endtask
  task automatic waitStep(input logic [2:0] s);
    int n;
    n = 0;
    while (resetStep !== s && n < 4000)
    begin
      @(posedge mclk);
      n++;
    end
    `check("reset step", s, resetStep)
  endtask
  task automatic pulseAt(input int which);
    {autoLoadDone, firmwareChange, unloadEject, modeChangeOther} <= 4'(1 << which);
    @(posedge mclk);
    {autoLoadDone, firmwareChange, unloadEject, modeChangeOther} <= 4'h0;
    @(posedge mclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sPowerOn();
    logic [1:0] r;
    waitStep(3'h2);
    axWrite(`REG_MSG, 32'h0000_000C, r);
    waitStep(3'h1);
    waitStep(3'h6);
    waitStep(3'h0);
    ask(3'h0, `OP_INQ, 24'h800000, 24'hB00000);
    ask(3'h0, `OP_SENSE, 24'h800000, 24'hB00000);
    ask(3'h0, `OP_TUR, 24'h162900, 24'hBFFF00);
    ask(3'h0, `OP_INQ, 24'h800000, 24'hB00000);
    ask(3'h0, `OP_TUR, 24'h123A00, 24'h3FFF00);
    ask(3'h0, `OP_READ, 24'h123A00, 24'h3FFF00);
    ask(3'h5, `OP_ERASE, 24'h162900, 24'hBFFF00);
  endtask
  task automatic sRegs();
    logic [1:0] r;
    logic [31:0] d;
    axRead(`REG_CTRL, d, r);
    `check("ctrl reset", `CTRL_RESET, d)
    axWrite(12'h0FC, 32'h0000_0001, r);
    `check("bresp", 2'h2, r)
    axRead(12'h0FC, d, r);
    `check("rresp", 34'h2_0000_0000, {r, d})
  endtask
  task automatic sEvents();
    pulseAt(0);
    pulseAt(2);
    ask(3'h1, `OP_READ, 24'h163F00, 24'hBFFF00);
    ask(3'h0, `OP_WRITE, 24'h163F00, 24'hBFFF00);
    pulseAt(3);
    ask(3'h1, `OP_VERIFY, 24'h162800, 24'hBFFF00);
    pulseAt(1);
    ask(3'h3, `OP_TUR, 24'h162800, 24'hBFFF00);
    ask(3'h3, `OP_SPACE, 24'h120000, 24'h3F0000);
  endtask
  task automatic sCartridge();
    logic [1:0] r;
    int n0;
    cartridgePin <= 1'b1;
    repeat (4) @(posedge mclk);
    n0 = nClear;
    axWrite(`REG_MSG, 32'h0000_000C, r);
    `check("queue clear", n0 + 1, nClear)
    waitStep(3'h7);
    ask(3'h4, `OP_TUR, 24'h162900, 24'hBFFF00);
    ask(3'h4, `OP_TUR, 24'h120401, 24'h3FFFFF);
    ask(3'h4, `OP_INQ, 24'h800000, 24'hB00000);
    axWrite(`REG_CTRL, 32'h0000_0001, r);
    ask(3'h4, `OP_READ, 24'h200000, 24'h300000);
    axWrite(`REG_CTRL, 32'h0000_0002, r);
    ask(3'h4, `OP_SPACE, 24'h120000, 24'h3F0000);
    axWrite(`REG_CTRL, 32'h0000_0000, r);
    ask(3'h4, `OP_LOCATE, 24'h300000, 24'h300000);
    tapeLoaded <= 1'b1;
    loadFinished <= 1'b1;
    @(posedge mclk);
    loadFinished <= 1'b0;
    waitStep(3'h0);
  endtask
  task automatic sBusReset();
    logic [1:0] r;
    logic [31:0] d;
    int n0;
    cartridgePin <= 1'b0;
    tapeLoaded <= 1'b0;
    n0 = nClear;
    start <= 1'b1;
    holdLen <= 12'h3E8;
    @(posedge mclk);
    start <= 1'b0;
    repeat (1100) @(posedge mclk);
    `check("short reset", n0, nClear)
    n0 = nResend;
    axWrite(`REG_MSG, 32'h0000_0109, r);
    axWrite(`REG_MSG, 32'h0000_0107, r);
    axRead(`REG_STATUS, d, r);
    `check("disconnect", 1'b0, d[17])
    axWrite(`REG_MSG, 32'h0000_0109, r);
    axWrite(`REG_MSG, 32'h0000_0109, r);
    `check("resends", n0 + 3, nResend)
    waitStep(3'h1);
    waitStep(3'h0);
    ask(3'h6, `OP_WFM, 24'h162900, 24'hBFFF00);
  endtask
  task automatic conclude();
    if (nMismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      nMismatch++;
      conclude();
    end
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    sPowerOn();
    sRegs();
    sEvents();
    sCartridge();
    sBusReset();
    conclude();
  end
endmodule // scsi_unit_attention_reset_ctrl_tb
